//--- verilog/crt_pkg.sv
// package: offsets, fields, reset values and carrier types of the rx buffer / trigger timer block
package crt_pkg;
  localparam int NODE_CNT = 4;            // controller nodes
  localparam int TRIG_CNT = 3;            // trigger timers a, b, c per node
  localparam int TMR_CNT  = 4;            // three trigger timers plus the timeout timer
  localparam int STS_W    = 7;            // status / enable bits per node
  localparam int RLD_W    = 16;           // reload field width
  localparam int PRE_W    = 8;            // prescaler width
  localparam int RBUF_WORDS = 2 * NODE_CNT; // 8 payload bytes per node

  // clocking: kernel clock is the bus clock, baud clock arrives as a tick
  localparam int REF_CLK_PERIOD_NS = 40;
  localparam int BAUD_CLK_MAX_MHZ  = 80;
  localparam int REF_CLK_MHZ       = 1000 / REF_CLK_PERIOD_NS;

  // register offsets inside one node window (node = adr[7:6])
  localparam logic [5:0] OFS_RXTT   = 6'h00; // rx_timeout_timer_reg
  localparam logic [5:0] OFS_IE     = 6'h04; // node_irq_enable_reg (mask)
  localparam logic [5:0] OFS_STS    = 6'h08; // sticky status, write one to clear
  localparam logic [5:0] OFS_CCFG   = 6'h0C; // timer_clock_config_reg
  localparam logic [5:0] OFS_TRIG_A = 6'h10; // tx_trigger_timer_a
  localparam logic [5:0] OFS_TRIG_B = 6'h14; // tx_trigger_timer_b
  localparam logic [5:0] OFS_TRIG_C = 6'h18; // tx_trigger_timer_c
  localparam logic [5:0] OFS_RBUF0  = 6'h20; // rx payload bytes 0..3
  localparam logic [5:0] OFS_RBUF1  = 6'h24; // rx payload bytes 4..7

  // field positions
  localparam int STS_TE      = 0;  // timeout_event_flag / timeout_irq_enable
  localparam int STS_F0      = 1;  // fifo0 new frame / fifo0_new_frame_irq_enable
  localparam int STS_F1      = 2;  // fifo1 new frame / fifo1_new_frame_irq_enable
  localparam int STS_DB      = 3;  // dedicated buffer / dedicated_buffer_irq_enable
  localparam int STS_TRIG    = 4;  // trigger a..c fired, bits 4..6
  localparam int TRIG_RUN    = 31; // timer_run_request
  localparam int TMR_BUSY    = 30; // trigger timer counting, read only; the timeout timer reads busy in bit 31
  localparam int CCFG_SRC    = 0;  // 0 kernel clock, 1 baud tick
  localparam int CCFG_PRE_LSB = 8; // prescaler field

  // reset values
  localparam logic [RLD_W-1:0] RST_RLD = 16'h0000;
  localparam logic [STS_W-1:0] RST_STS = 7'h00;
  localparam logic [PRE_W-1:0] RST_PRE = 8'h00;

  // receive storage kinds
  localparam logic [1:0] KIND_FIFO0 = 2'h0;
  localparam logic [1:0] KIND_FIFO1 = 2'h1;
  localparam logic [1:0] KIND_DED   = 2'h2;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } crt_wb_req_t;

  typedef struct packed {
    logic        store;
    logic [1:0]  node;
    logic [1:0]  kind;
    logic [3:0]  dlc;
    logic [63:0] data;
  } crt_frame_t;

  typedef struct packed {
    logic [RLD_W:0] cnt;
    logic           busy;
    logic           fire;
  } crt_tmr_state_t;

  typedef struct packed {
    logic                                       ack;
    logic [31:0]                                dat;
    logic [NODE_CNT-1:0][RLD_W-1:0]             rxtt;
    logic [NODE_CNT-1:0][STS_W-1:0]             ie;
    logic [NODE_CNT-1:0][STS_W-1:0]             sts;
    logic [NODE_CNT-1:0]                        src;
    logic [NODE_CNT-1:0][PRE_W-1:0]             pre;
    logic [NODE_CNT-1:0][PRE_W-1:0]             pcnt;
    logic [NODE_CNT-1:0][TRIG_CNT-1:0][RLD_W-1:0] trig;
    logic [RBUF_WORDS-1:0][31:0]                rbuf;
    logic                                       int_o;
    logic                                       irq_o;
    logic [NODE_CNT*TRIG_CNT-1:0]               tx;
  } crt_state_t;
endpackage

//--- verilog/crt_timer.sv
// one reload counter used for the trigger timers and the receive timeout
`timescale 1ns/1ps
module crt_timer #(
  parameter int RLD_W = 16, // reload width
  parameter int EXTRA = 0,  // extra steps counted past reload
  parameter bit AUTO  = 0   // restart after firing
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // control
  input  wire logic             tick,   // one count step
  input  wire logic             load,   // restart, count back to one
  input  wire logic             run,    // start with the load
  input  wire logic             en,     // timer allowed to count
  input  wire logic [RLD_W-1:0] reload, // reload value
  // results
  output logic                  fire,   // one-cycle expiry pulse
  output logic                  busy    // counting
);
  typedef struct packed {
    logic [RLD_W:0] cnt;
    logic           busy;
    logic           fire;
  } crt_tmr_t;

  crt_tmr_t       st_r;   // all state
  crt_tmr_t       st_nxt; // next state
  logic [RLD_W:0] target; // steps counted before firing

  // count reload+EXTRA steps, then fire
  always_comb begin
    st_nxt      = st_r;
    st_nxt.fire = 1'b0;
    target      = {1'b0, reload} + (RLD_W+1)'(EXTRA);
    if (!en) begin
      st_nxt.busy = 1'b0;
    end else if (load) begin
      // count starts at one so the firing step is step number target
      st_nxt.cnt  = (RLD_W+1)'(1);
      st_nxt.busy = run;
    end else if (st_r.busy && tick) begin
      if (st_r.cnt == target) begin
        st_nxt.fire = 1'b1;
        st_nxt.cnt  = (RLD_W+1)'(1);
        st_nxt.busy = AUTO; // timeout rearms, trigger is one shot
      end else begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fire = st_r.fire;
  assign busy = st_r.busy;

  // helper: ticks seen since the last start or expiry
  logic [RLD_W+1:0] tcnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tcnt_r <= '0;
    end else if (load || !en) begin
      tcnt_r <= '0;
    end else if (st_r.fire) begin
      tcnt_r <= (RLD_W+2)'(st_r.busy && tick);
    end else if (st_r.busy && tick) begin
      tcnt_r <= tcnt_r + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_FIRE_AFTER_STEPS: assert property (
    fire |-> tcnt_r == (RLD_W+2)'({1'b0, reload}) + (RLD_W+2)'(EXTRA))
    else $error("timer fired at wrong step count");
  AST_IDLE_WHEN_OFF: assert property (
    !en |=> !busy ##1 !fire)
    else $error("disabled timer still active");
  AST_START_ON_RUN: assert property (
    (en && load && run) |=> busy)
    else $error("timer did not start on run request");
  COV_FIRE: cover property (load && run ##[1:40] fire);
endmodule // crt_timer

//--- verilog/crt_top.sv
// rx buffer fill, receive timeout and time-triggered transmit timers for four nodes
`timescale 1ns/1ps
module crt_top (
  // clock and reset
  input  wire logic                REF_CLK,
  input  wire logic                ARST_N,
  // wishbone slave
  input  wire logic                WB_CYC_I,
  input  wire logic                WB_STB_I,
  input  wire logic                WB_WE_I,
  input  wire logic [7:0]          WB_ADR_I,
  input  wire logic [3:0]          WB_SEL_I,
  input  wire logic [31:0]         WB_DAT_I,
  output logic      [31:0]         WB_DAT_O,
  output logic                     WB_ACK_O,
  // baud clock tick, synchronous to REF_CLK
  input  wire logic                BAUD_TICK,
  // received frame from the protocol engine
  input  wire logic                RX_STORE,
  input  wire logic [1:0]          RX_NODE,
  input  wire logic [1:0]          RX_KIND,
  input  wire logic [3:0]          RX_DLC,
  input  wire logic [63:0]         RX_DATA,
  // transmit triggers and interrupts
  output logic      [11:0]         TX_TRIG,
  output logic                     INT,
  output logic                     IRQ_REQ
);
  localparam int N = crt_pkg::NODE_CNT;
  localparam int T = crt_pkg::TRIG_CNT;

  logic                   rst_s1_r;  // reset release, stage one
  logic                   rst_n;     // reset release, stage two
  crt_pkg::crt_wb_req_t   req;       // bus request carrier
  crt_pkg::crt_frame_t    fr;        // frame carrier
  crt_pkg::crt_state_t    st_r;      // all state
  crt_pkg::crt_state_t    st_nxt;    // next state
  logic                   take;      // request taken this cycle
  logic [1:0]             nd;        // addressed node
  logic [5:0]             ofs;       // offset inside node window
  logic [31:0]            rd;        // read mux
  logic [N-1:0]           tick;      // prescaled timer step
  logic [N-1:0][T:0]      fire;      // timer expiry, index T is timeout
  logic [N-1:0][T:0]      busy;      // timer counting
  logic [N-1:0][T:0]      load;      // timer restart
  logic [N-1:0][T-1:0]    run;       // start requests
  logic [N-1:0][crt_pkg::STS_W-1:0] set; // hardware events
  logic [N-1:0][crt_pkg::STS_W-1:0] clr; // software clears
  logic [3:0]             nbytes;    // payload bytes to store
  logic [31:0]            wv;        // write value after byte enables

  // merge byte lanes of a write
  function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // reset release through two flip-flops
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I,
                 sel: WB_SEL_I, dat: WB_DAT_I};
  assign fr  = '{store: RX_STORE, node: RX_NODE, kind: RX_KIND, dlc: RX_DLC,
                 data: RX_DATA};

  // timers: three one-shot triggers and one rearming timeout per node
  // reload and the timeout enable come from the next state, so a register write and the
  // restart that it causes see the same value in the same cycle
  for (genvar n = 0; n < N; n++) begin : g_node
    for (genvar k = 0; k < T; k++) begin : g_trig
      crt_timer #(.RLD_W(crt_pkg::RLD_W), .EXTRA(1), .AUTO(1'b0)) u_trig (
        .clk    (REF_CLK),
        .rst_n  (rst_n),
        .tick   (tick[n]),
        .load   (load[n][k]),
        .run    (run[n][k]),
        .en     (1'b1),
        .reload (st_nxt.trig[n][k]),
        .fire   (fire[n][k]),
        .busy   (busy[n][k])
      );
    end
    crt_timer #(.RLD_W(crt_pkg::RLD_W), .EXTRA(0), .AUTO(1'b1)) u_tout (
      .clk    (REF_CLK),
      .rst_n  (rst_n),
      .tick   (tick[n]),
      .load   (load[n][T]),
      .run    (1'b1),
      .en     (st_nxt.rxtt[n] != crt_pkg::RST_RLD),
      .reload (st_nxt.rxtt[n]),
      .fire   (fire[n][T]),
      .busy   (busy[n][T])
    );
  end

  // next state: bus slave, prescalers, frame store, status and interrupts
  always_comb begin
    st_nxt = st_r;
    load   = '0;
    run    = '0;
    set    = '0;
    clr    = '0;
    rd     = '0;
    tick   = '0;
    take   = req.cyc && req.stb && !st_r.ack;
    nd     = req.adr[7:6];
    ofs    = req.adr[5:0];
    nbytes = (fr.dlc > 4'h8) ? 4'h8 : fr.dlc; // classic payload only
    // one wait state: ack one cycle after the request is seen
    st_nxt.ack = take;
    // per-node time base: source then prescaler
    // limitation: baud steps are seen once per kernel clock, so they must come slower
    for (int n = 0; n < N; n++) begin
      if (st_r.src[n] ? BAUD_TICK : 1'b1) begin
        if (st_r.pcnt[n] == st_r.pre[n]) begin
          st_nxt.pcnt[n] = '0;
          tick[n]        = 1'b1;
        end else begin
          st_nxt.pcnt[n] = st_r.pcnt[n] + 1'b1;
        end
      end
    end
    // read mux, unmapped offsets read zero
    // trigger busy reads back in bit 30; the run request bit is write only
    case (ofs)
      crt_pkg::OFS_RXTT: rd = {busy[nd][T], 15'h0000, st_r.rxtt[nd]};
      crt_pkg::OFS_IE:   rd = {25'h0000000, st_r.ie[nd]};
      crt_pkg::OFS_STS:  rd = {25'h0000000, st_r.sts[nd]};
      crt_pkg::OFS_CCFG: rd = {16'h0000, st_r.pre[nd], 7'h00, st_r.src[nd]};
      crt_pkg::OFS_TRIG_A, crt_pkg::OFS_TRIG_B, crt_pkg::OFS_TRIG_C: begin
        rd = {1'b0, busy[nd][ofs[3:2]], 14'h0000, st_r.trig[nd][ofs[3:2]]};
      end
      crt_pkg::OFS_RBUF0: rd = st_r.rbuf[{nd, 1'b0}];
      crt_pkg::OFS_RBUF1: rd = st_r.rbuf[{nd, 1'b1}];
      default:           rd = '0;
    endcase
    wv = bmerge(rd, req.dat, req.sel);
    if (take) begin
      st_nxt.dat = rd;
    end
    // register writes; payload words are read only
    if (take && req.we) begin
      case (ofs)
        crt_pkg::OFS_RXTT: begin
          st_nxt.rxtt[nd] = wv[crt_pkg::RLD_W-1:0];
          load[nd][T]     = 1'b1;
        end
        crt_pkg::OFS_IE:   st_nxt.ie[nd] = wv[crt_pkg::STS_W-1:0];
        crt_pkg::OFS_STS:  clr[nd] = req.dat[crt_pkg::STS_W-1:0] & {7{req.sel[0]}};
        crt_pkg::OFS_CCFG: begin
          st_nxt.src[nd] = wv[crt_pkg::CCFG_SRC];
          st_nxt.pre[nd] = wv[crt_pkg::CCFG_PRE_LSB +: crt_pkg::PRE_W];
        end
        crt_pkg::OFS_TRIG_A, crt_pkg::OFS_TRIG_B, crt_pkg::OFS_TRIG_C: begin
          st_nxt.trig[nd][ofs[3:2]] = wv[crt_pkg::RLD_W-1:0];
          load[nd][ofs[3:2]]        = 1'b1;
          run[nd][ofs[3:2]]         = wv[crt_pkg::TRIG_RUN];
        end
        default: ; // unmapped writes ignored, still acknowledged
      endcase
    end
    // frame store: only dlc bytes land, stale bytes stay
    // a frame and a status clear may share an edge; the set then wins
    if (fr.store) begin
      for (int b = 0; b < 8; b++) begin
        if (4'(b) < nbytes) begin
          st_nxt.rbuf[{fr.node, 1'(b / 4)}][(b % 4) * 8 +: 8] = fr.data[b*8 +: 8];
        end
      end
      case (fr.kind)
        crt_pkg::KIND_FIFO0: begin
          set[fr.node][crt_pkg::STS_F0] = 1'b1;
          load[fr.node][T] = st_r.ie[fr.node][crt_pkg::STS_F0];
        end
        crt_pkg::KIND_FIFO1: begin
          set[fr.node][crt_pkg::STS_F1] = 1'b1;
          load[fr.node][T] = st_r.ie[fr.node][crt_pkg::STS_F1];
        end
        crt_pkg::KIND_DED: begin
          set[fr.node][crt_pkg::STS_DB] = 1'b1;
          load[fr.node][T] = st_r.ie[fr.node][crt_pkg::STS_DB];
        end
        default: ;
      endcase
    end
    // sticky status; the timeout flag lets the clear win
    // so software can always silence a timeout that keeps rearming
    for (int n = 0; n < N; n++) begin
      set[n][crt_pkg::STS_TE] = fire[n][T];
      for (int k = 0; k < T; k++) begin
        set[n][crt_pkg::STS_TRIG + k] = fire[n][k];
        st_nxt.tx[n*T + k]            = fire[n][k];
      end
      st_nxt.sts[n] = (st_r.sts[n] & ~clr[n]) | set[n];
      if (clr[n][crt_pkg::STS_TE]) begin
        st_nxt.sts[n][crt_pkg::STS_TE] = 1'b0;
      end
    end
    // level output and rising-edge request
    st_nxt.int_o = 1'b0;
    st_nxt.irq_o = 1'b0;
    for (int n = 0; n < N; n++) begin
      st_nxt.int_o = st_nxt.int_o | (|(st_nxt.sts[n] & st_nxt.ie[n]));
      st_nxt.irq_o = st_nxt.irq_o | (|(st_nxt.sts[n] & ~st_r.sts[n] & st_nxt.ie[n]));
    end
  end

  // state register; one flop stage behind every output
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign WB_ACK_O = st_r.ack;
  assign WB_DAT_O = st_r.dat;
  assign TX_TRIG  = st_r.tx;
  assign INT      = st_r.int_o;
  assign IRQ_REQ  = st_r.irq_o;

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n);

  AST_ACK_ONE_CYCLE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  AST_ACK_NEXT: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
    else $error("ack missing after request");
  AST_KEEP_STALE_BYTES: assert property (
    (RX_STORE && RX_DLC == 4'h0) |=> $stable(st_r.rbuf))
    else $error("zero-length frame altered payload");
  AST_SET_BEATS_CLEAR: assert property (
    (take && req.we && ofs == crt_pkg::OFS_STS && nd == 2'h0 && req.sel[0] &&
     req.dat[crt_pkg::STS_F0] && RX_STORE && RX_NODE == 2'h0 &&
     RX_KIND == crt_pkg::KIND_FIFO0) |=> st_r.sts[0][crt_pkg::STS_F0])
    else $error("clear won over a new frame event");
  AST_TE_CLEAR_WINS: assert property (
    (take && req.we && ofs == crt_pkg::OFS_STS && nd == 2'h0 && req.sel[0] &&
     req.dat[crt_pkg::STS_TE]) |=> !st_r.sts[0][crt_pkg::STS_TE])
    else $error("timeout flag not cleared");
  AST_IRQ_ON_RISE: assert property (
    IRQ_REQ |-> (st_r.sts[0] & ~$past(st_r.sts[0])) != 7'h00 ||
                (st_r.sts[1] & ~$past(st_r.sts[1])) != 7'h00 ||
                (st_r.sts[2] & ~$past(st_r.sts[2])) != 7'h00 ||
                (st_r.sts[3] & ~$past(st_r.sts[3])) != 7'h00)
    else $error("request without a rising flag");
  AST_TRIG_TO_PIN: assert property (
    fire[1][2] |=> TX_TRIG[5] && st_r.sts[1][crt_pkg::STS_TRIG + 2])
    else $error("trigger fire not reflected");
  AST_STORE_NO_RELOAD: assert property (
    (RX_STORE && RX_NODE == 2'h2 && RX_KIND == crt_pkg::KIND_FIFO0 &&
     !st_r.ie[2][crt_pkg::STS_F0] &&
     !(take && req.we && ofs == crt_pkg::OFS_RXTT && nd == 2'h2)) |-> !load[2][T])
    else $error("timeout reloaded without new-frame enable");
  // timeout, payload and prescaler checks watch the nodes the bench exercises
  AST_TOUT_SILENT_ZERO: assert property (
    (st_nxt.rxtt[2] == crt_pkg::RST_RLD) |=> !fire[2][T])
    else $error("timeout fired with zero reload");
  AST_SHORT_FRAME_BYTES: assert property (
    (RX_STORE && RX_NODE == 2'h1 && RX_DLC == 4'h3) |=>
      st_r.rbuf[2][31:24] == $past(st_r.rbuf[2][31:24]) &&
      st_r.rbuf[2][23:0] == $past(RX_DATA[23:0]) && $stable(st_r.rbuf[3]))
    else $error("short frame wrote the wrong bytes");
  AST_PRESCALE_HOLD: assert property (
    (st_r.src[3] && !BAUD_TICK) |=> st_r.pcnt[3] == $past(st_r.pcnt[3]))
    else $error("prescaler moved without a baud step");

  COV_TRIG_SEND: cover property (load[0][0] && run[0][0] ##[1:60] TX_TRIG[0]);
  COV_TIMEOUT: cover property (st_r.sts[2][crt_pkg::STS_TE] && INT);
  COV_COLLIDE: cover property (RX_STORE && take && req.we && ofs == crt_pkg::OFS_STS);
  COV_SHORT_FRAME: cover property (RX_STORE && RX_DLC == 4'h3);
endmodule // crt_top

//--- tb/crt_rx_model.sv
// frame source standing in for the protocol engine and the bus nodes behind it
`timescale 1ns/1ps
module crt_rx_model (
  // clock
  input  wire logic        clk,
  // stored frame strobe and its payload
  output logic             store,
  output logic [1:0]       node,
  output logic [1:0]       kind,
  output logic [3:0]       dlc,
  output logic [63:0]      data
);
  // idle until the bench asks for a frame
  initial begin
    store = 1'b0;
    node  = 2'h0;
    kind  = 2'h3;
    dlc   = 4'h0;
    data  = 64'h0;
  end

  // one frame store: strobe for one cycle, then drop the qualified lines
  task automatic send(input logic [1:0] n, input logic [1:0] k, input logic [3:0] d,
                      input logic [63:0] v);
    @(posedge clk);
    store <= 1'b1;
    node  <= n;
    kind  <= k;
    dlc   <= d;
    data  <= v;
    @(posedge clk);
    store <= 1'b0;
    // payload no longer valid: show a different value so stale bytes are not trusted
    data  <= ~v;
    kind  <= 2'h3;
  endtask
endmodule // crt_rx_model

//--- tb/crt_top_tb.sv
// self-checking bench for the rx buffer, receive timeout and trigger timers
`timescale 1ns/1ps
module crt_top_tb;
  // clock, reset and baud step
  logic                 ref_clk   = 1'b0;
  logic                 arst_n    = 1'b0;
  logic                 baud_tick = 1'b0;
  // bus request carrier and answers
  crt_pkg::crt_wb_req_t wb        = '0;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;
  logic [31:0]          rdat;
  // frame lines from the model
  logic                 rx_store;
  logic [1:0]           rx_node;
  logic [1:0]           rx_kind;
  logic [3:0]           rx_dlc;
  logic [63:0]          rx_data;
  // outputs under test
  logic [11:0]          tx_trig;
  logic                 int_o;
  logic                 irq_req;
  logic [11:0]          got;
  // counters
  int                   fail_count = 0;
  int                   compares   = 0;
  int                   cycles     = 0;
  int                   irq_n      = 0;
  int                   n0;
  int                   fire;
  logic [5:0]           ofs_tab [10] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14,
                                         6'h18, 6'h20, 6'h24, 6'h30};

  always #20 ref_clk = ~ref_clk;

  crt_rx_model i_rx (.clk(ref_clk), .store(rx_store), .node(rx_node), .kind(rx_kind),
                     .dlc(rx_dlc), .data(rx_data));

  crt_top i_dut (.REF_CLK(ref_clk), .ARST_N(arst_n), .WB_CYC_I(wb.cyc),
                 .WB_STB_I(wb.stb), .WB_WE_I(wb.we), .WB_ADR_I(wb.adr),
                 .WB_SEL_I(wb.sel), .WB_DAT_I(wb.dat), .WB_DAT_O(wb_dat_o),
                 .WB_ACK_O(wb_ack_o), .BAUD_TICK(baud_tick), .RX_STORE(rx_store),
                 .RX_NODE(rx_node), .RX_KIND(rx_kind), .RX_DLC(rx_dlc),
                 .RX_DATA(rx_data), .TX_TRIG(tx_trig), .INT(int_o), .IRQ_REQ(irq_req));

  // interrupt request pulses, counted to spot repeats
  always @(posedge ref_clk) begin
    if (irq_req === 1'b1) begin
      irq_n <= irq_n + 1;
    end
  end

  // hang guard: the sequence needs a few hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // byte address: node in the top two bits
  function automatic logic [7:0] ra(input logic [1:0] n, input logic [5:0] o);
    return {n, o};
  endfunction

  // classic single cycle; held until ack is sampled high at a rising edge,
  // read data taken at that edge; a bus that never answers ends in the hang guard
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge ref_clk);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: d};
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) begin
      @(posedge ref_clk);
    end
    rdat = wb_dat_o;
    wb <= '0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    xfer(1'b1, adr, d);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] e);
    xfer(1'b0, adr, 32'h0);
    check(rdat, e);
  endtask

  // look for a trigger pulse over a number of cycles
  task automatic scan(input int lim);
    got = 12'h000;
    for (int i = 0; i < lim && got == 12'h000; i++) begin
      @(negedge ref_clk);
      got = tx_trig;
    end
  endtask

  initial begin
    // reset held eight cycles, then the release settles through the synchroniser
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // cleared registers, a read-only payload word and an unmapped hole
    for (int i = 0; i < 10; i++) begin
      rd(ra(2'h0, ofs_tab[i]), 32'h0);
    end
    wr(ra(2'h0, crt_pkg::OFS_RBUF0), 32'hFFFF_FFFF);
    rd(ra(2'h0, crt_pkg::OFS_RBUF0), 32'h0);
    // rising flag gives one request; a flag that stays set gives none
    wr(ra(2'h0, crt_pkg::OFS_IE), 32'h2);
    n0 = irq_n;
    i_rx.send(2'h0, crt_pkg::KIND_FIFO0, 4'h8, 64'h1);
    repeat (3) @(posedge ref_clk);
    check(irq_n, n0 + 1);
    @(negedge ref_clk);
    check({31'h0, int_o}, 32'h1);
    i_rx.send(2'h0, crt_pkg::KIND_FIFO0, 4'h8, 64'h2);
    repeat (3) @(posedge ref_clk);
    check(irq_n, n0 + 1);
    // clear and a new frame on the same edge: the frame wins
    fork
      wr(ra(2'h0, crt_pkg::OFS_STS), 32'h2);
      i_rx.send(2'h0, crt_pkg::KIND_FIFO0, 4'h1, 64'h3);
    join
    rd(ra(2'h0, crt_pkg::OFS_STS), 32'h2);
    check(irq_n, n0 + 1);
    // masking drops the level, clearing empties status
    wr(ra(2'h0, crt_pkg::OFS_IE), 32'h0);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check({31'h0, int_o}, 32'h0);
    wr(ra(2'h0, crt_pkg::OFS_STS), 32'h7F);
    rd(ra(2'h0, crt_pkg::OFS_STS), 32'h0);
    // short frames leave older bytes; every storage kind flags its own bit
    i_rx.send(2'h1, crt_pkg::KIND_FIFO0, 4'h8, 64'h8877_6655_4433_2211);
    i_rx.send(2'h1, crt_pkg::KIND_FIFO1, 4'h3, 64'hFFEE_DDCC_BBAA_9988);
    i_rx.send(2'h1, crt_pkg::KIND_DED, 4'h0, 64'h0);
    rd(ra(2'h1, crt_pkg::OFS_RBUF0), 32'h44AA_9988);
    check(rdat & 32'h00FF_FFFF, 32'h00AA_9988);
    rd(ra(2'h1, crt_pkg::OFS_RBUF1), 32'h8877_6655);
    rd(ra(2'h1, crt_pkg::OFS_STS), 32'h0E);
    // zero reload keeps the timeout silent
    wr(ra(2'h2, crt_pkg::OFS_IE), 32'h1);
    wr(ra(2'h2, crt_pkg::OFS_RXTT), 32'h0);
    repeat (40) @(posedge ref_clk);
    rd(ra(2'h2, crt_pkg::OFS_STS), 32'h0);
    wr(ra(2'h2, crt_pkg::OFS_RXTT), 32'd20);
    repeat (30) @(posedge ref_clk);
    rd(ra(2'h2, crt_pkg::OFS_STS), 32'h1);
    @(negedge ref_clk);
    check({31'h0, int_o}, 32'h1);
    // frames without their new-frame enable do not hold the timeout off
    wr(ra(2'h2, crt_pkg::OFS_RXTT), 32'd20);
    wr(ra(2'h2, crt_pkg::OFS_STS), 32'h7F);
    for (int i = 0; i < 4; i++) begin
      i_rx.send(2'h2, crt_pkg::KIND_FIFO0, 4'h2, 64'h5);
      repeat (8) @(posedge ref_clk);
    end
    rd(ra(2'h2, crt_pkg::OFS_STS), 32'h3);
    // with the matching enable set each frame reloads the timeout
    wr(ra(2'h2, crt_pkg::OFS_IE), 32'h3);
    wr(ra(2'h2, crt_pkg::OFS_RXTT), 32'd20);
    wr(ra(2'h2, crt_pkg::OFS_STS), 32'h7F);
    for (int i = 0; i < 4; i++) begin
      i_rx.send(2'h2, crt_pkg::KIND_FIFO0, 4'h2, 64'h6);
      repeat (8) @(posedge ref_clk);
    end
    rd(ra(2'h2, crt_pkg::OFS_STS), 32'h2);
    wr(ra(2'h2, crt_pkg::OFS_RXTT), 32'h0);
    // each of the twelve trigger timers fires its own output bit
    for (int n = 0; n < 4; n++) begin
      for (int k = 0; k < 3; k++) begin
        wr(ra(2'(n), crt_pkg::OFS_TRIG_A + 6'(4 * k)), 32'h8000_0004);
        scan(20);
        check({20'h0, got}, 32'h1 << (n * 3 + k));
      end
    end
    // baud steps with prescale one: nothing moves without steps, fire past reload
    wr(ra(2'h3, crt_pkg::OFS_CCFG), 32'h0000_0101);
    wr(ra(2'h3, crt_pkg::OFS_TRIG_A), 32'h8000_0002);
    scan(20);
    check({20'h0, got}, 32'h0);
    fire = 0;
    for (int i = 1; i <= 12 && fire == 0; i++) begin
      @(posedge ref_clk);
      baud_tick <= 1'b1;
      @(posedge ref_clk);
      baud_tick <= 1'b0;
      scan(4);
      if (got !== 12'h000) begin
        fire = i;
      end
    end
    // reload 2 is one below three steps, two baud ticks per step at prescale one
    check(fire, (2 + 1) * (1 + 1));
    check({20'h0, got}, 32'h200);
    print_verdict();
  end
endmodule // crt_top_tb
